/* inc/tblo_pkg.sv */
package tblo_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PIX_W = 12;
    localparam int unsigned SET_W = 10;
    localparam int unsigned NTAP = 4;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OFF_SEL = 8'h04;
    localparam logic [7:0] OFS_OFF_VAL = 8'h08;
    localparam logic [7:0] OFS_GAIN_SEL = 8'h0c;
    localparam logic [7:0] OFS_GAIN_VAL = 8'h10;
    localparam logic [7:0] OFS_LIM_SEL = 8'h14;
    localparam logic [7:0] OFS_WIDEN = 8'h18;
    localparam logic [7:0] OFS_PRELINES = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // ----------------------------------------
    // Fields and codes
    // ----------------------------------------
    localparam int unsigned CTRL_FOUR_BIT = 0;
    localparam int unsigned CTRL_DEPTH12_BIT = 1;
    localparam logic [2:0] SEL_ALL = 3'h0;
    localparam logic [2:0] SEL_TAP4 = 3'h4;
    localparam logic [1:0] LIM_GAIN = 2'h0;
    localparam logic [1:0] LIM_PRELINES = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic RST_FOUR = 1'b1;
    localparam logic RST_DEPTH12 = 1'b0;
    localparam logic [SET_W-1:0] RST_SET = 10'h000;
    localparam logic [SET_W-1:0] RST_PRELINES = 10'h001;

    // ----------------------------------------
    // Ranges and scaling
    // ----------------------------------------
    localparam logic [31:0] OFF_MIN = 32'h0000_0000;
    localparam logic [31:0] OFF_MAX = 32'h0000_03b6;
    localparam logic [10:0] OFF_SUM_MAX = 11'h3b6;
    localparam logic [31:0] GAIN_MAX = 32'h0000_0258;
    localparam logic [31:0] GAIN_EXT_MAX = 32'h0000_03ff;
    localparam logic [31:0] PRE_MIN = 32'h0000_0001;
    localparam logic [31:0] PRE_MAX = 32'h0000_000f;
    localparam logic [31:0] PRE_EXT_MIN = 32'h0000_0000;
    localparam logic [31:0] PRE_EXT_MAX = 32'h0000_003f;
    localparam int unsigned SHIFT_8BIT = 6;
    localparam int unsigned SHIFT_12BIT = 2;
    localparam logic [12:0] SAT_8BIT = 13'h00ff;
    localparam logic [12:0] SAT_12BIT = 13'h0fff;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_DO = 3'b010,
        WR_RESP = 3'b100
    } tblo_wr_e;

    typedef struct packed {
        logic valid;
        logic [1:0] tap;
        logic [PIX_W-1:0] data;
    } tblo_pix_s;

    typedef struct packed {
        logic [NTAP-1:0][SET_W-1:0] gain_eff;
        logic [SET_W-1:0] prelines;
    } tblo_cfg_s;
endpackage

/* hw/tblo_clamp.sv */
`timescale 1ns/1ps
module tblo_clamp #(
    parameter int unsigned W = 32
) (
    // Value and range
    input wire logic [W-1:0] val,
    input wire logic [W-1:0] lo,
    input wire logic [W-1:0] hi,
    // Limited result
    output logic [W-1:0] res
);
    always_comb begin
        if (val < lo) begin
            res = lo;
        end else if (val > hi) begin
            res = hi;
        end else begin
            res = val;
        end
    end
endmodule

/* hw/tblo_offset_top.sv */
// Notes on behaviour
// - Four-tap mode keeps one global offset and four per-tap offsets.
// - Tap offsets 1..4 go to top-left, top-right, bottom-left, bottom-right.
// - Quadrant offset is global offset plus that quadrant's tap offset.
// - At 8-bit depth, 64 setting steps move output by one code.
// - At 12-bit depth, 4 setting steps move output by one code.
// - One-tap mode exposes only the global offset, same range and scaling.
// - One-tap mode exposes only the global gain, same range and behaviour.
// - Written values outside range become the range minimum or maximum.
// - Select a parameter, then set the widen flag to extend limits.
// - Only gain and prelines can be widened; others keep factory ranges.
// - Offset write lands only in the setting chosen by the selector.
// - Gain settings and global-plus-tap gain sums stay within 0..600, or 0..1023 with gain widened.
`timescale 1ns/1ps
module tblo_offset_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pixel stream
    input tblo_pkg::tblo_pix_s pix_in,
    output tblo_pkg::tblo_pix_s pix_out,
    // Settings for later stages
    output tblo_pkg::tblo_cfg_s cfg_out
);
    localparam int unsigned SW = tblo_pkg::SET_W;

    tblo_pkg::tblo_wr_e wst_q;
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic four_q, depth12_q;
    logic [2:0] off_sel_q, gain_sel_q;
    logic [1:0] lim_sel_q;
    logic widen_gain_q, widen_pre_q;
    logic [SW-1:0] off_all_q, gain_all_q, pre_q;
    logic [3:0][SW-1:0] off_tap_q, gain_tap_q;

    logic aw_hs, w_hs, ar_hs, wr_go, wr_ok, sel_tap_off, sel_tap_gain;
    logic wr_off, wr_gain, wr_pre, wr_widen;
    logic [1:0] off_idx, gain_idx;
    logic [SW-1:0] gain_tmax;
    logic [31:0] gain_lim, gain_hi, off_res, gain_res, pre_res, pre_lo, pre_hi, rd_d;

    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_go = (wst_q == tblo_pkg::WR_DO);
    assign wr_ok = wr_go && (w_strb_q[1:0] == 2'b11);
    assign off_idx = 2'(off_sel_q - 3'h1);
    assign gain_idx = 2'(gain_sel_q - 3'h1);
    // Tap selectors only reach storage in four-tap mode
    assign sel_tap_off = four_q && off_sel_q != tblo_pkg::SEL_ALL
        && off_sel_q <= tblo_pkg::SEL_TAP4;
    assign sel_tap_gain = four_q && gain_sel_q != tblo_pkg::SEL_ALL
        && gain_sel_q <= tblo_pkg::SEL_TAP4;
    assign wr_off = wr_ok && aw_addr_q == tblo_pkg::OFS_OFF_VAL;
    assign wr_gain = wr_ok && aw_addr_q == tblo_pkg::OFS_GAIN_VAL;
    assign wr_pre = wr_ok && aw_addr_q == tblo_pkg::OFS_PRELINES;
    assign wr_widen = wr_ok && aw_addr_q == tblo_pkg::OFS_WIDEN;

    // ----------------------------------------
    // AXI write channels
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (aw_hs) begin
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
        end else begin
            if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            s_axi_awready <= !aw_have_q && wst_q == tblo_pkg::WR_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            w_have_q <= 1'b0;
            s_axi_wready <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (w_hs) begin
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else begin
            if (wr_go) begin
                w_have_q <= 1'b0;
            end
            s_axi_wready <= !w_have_q && wst_q == tblo_pkg::WR_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wst_q <= tblo_pkg::WR_IDLE;
        end else begin
            case (wst_q)
                tblo_pkg::WR_IDLE: begin
                    if (aw_have_q && w_have_q) begin
                        wst_q <= tblo_pkg::WR_DO;
                    end
                end
                tblo_pkg::WR_DO: wst_q <= tblo_pkg::WR_RESP;
                tblo_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        wst_q <= tblo_pkg::WR_IDLE;
                    end
                end
                default: wst_q <= tblo_pkg::WR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tblo_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q > tblo_pkg::OFS_PRELINES || aw_addr_q[1:0] != 2'b00)
                ? tblo_pkg::RESP_SLVERR : tblo_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Range limits
    // ----------------------------------------
    always_comb begin
        gain_tmax = gain_tap_q[0];
        for (int i = 1; i < 4; i++) begin
            if (gain_tap_q[i] > gain_tmax) begin
                gain_tmax = gain_tap_q[i];
            end
        end
        gain_lim = widen_gain_q ? tblo_pkg::GAIN_EXT_MAX : tblo_pkg::GAIN_MAX;
        // Headroom keeps every global-plus-tap sum in range
        if (sel_tap_gain) begin
            gain_hi = (gain_lim > 32'(gain_all_q)) ? gain_lim - 32'(gain_all_q) : 32'h0;
        end else begin
            gain_hi = (gain_lim > 32'(gain_tmax)) ? gain_lim - 32'(gain_tmax) : 32'h0;
        end
        pre_lo = widen_pre_q ? tblo_pkg::PRE_EXT_MIN : tblo_pkg::PRE_MIN;
        pre_hi = widen_pre_q ? tblo_pkg::PRE_EXT_MAX : tblo_pkg::PRE_MAX;
    end

    tblo_clamp #(.W(32)) u_off_clamp (
        .val(w_data_q), .lo(tblo_pkg::OFF_MIN), .hi(tblo_pkg::OFF_MAX), .res(off_res)
    );
    tblo_clamp #(.W(32)) u_gain_clamp (
        .val(w_data_q), .lo(32'h0), .hi(gain_hi), .res(gain_res)
    );
    tblo_clamp #(.W(32)) u_pre_clamp (
        .val(w_data_q), .lo(pre_lo), .hi(pre_hi), .res(pre_res)
    );

    // ----------------------------------------
    // Settings storage
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            four_q <= tblo_pkg::RST_FOUR;
            depth12_q <= tblo_pkg::RST_DEPTH12;
            off_sel_q <= tblo_pkg::SEL_ALL;
            gain_sel_q <= tblo_pkg::SEL_ALL;
            lim_sel_q <= tblo_pkg::LIM_GAIN;
        end else if (wr_ok) begin
            case (aw_addr_q)
                tblo_pkg::OFS_CTRL: begin
                    four_q <= w_data_q[tblo_pkg::CTRL_FOUR_BIT];
                    depth12_q <= w_data_q[tblo_pkg::CTRL_DEPTH12_BIT];
                end
                tblo_pkg::OFS_OFF_SEL: off_sel_q <= w_data_q[2:0];
                tblo_pkg::OFS_GAIN_SEL: gain_sel_q <= w_data_q[2:0];
                tblo_pkg::OFS_LIM_SEL: lim_sel_q <= w_data_q[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            off_all_q <= tblo_pkg::RST_SET;
            off_tap_q <= '0;
        end else if (wr_off) begin
            if (off_sel_q == tblo_pkg::SEL_ALL) begin
                off_all_q <= off_res[SW-1:0];
            end else if (sel_tap_off) begin
                off_tap_q[off_idx] <= off_res[SW-1:0];
            end
        end
    end

    // Only gain and prelines carry a widen flag
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            widen_gain_q <= 1'b0;
            widen_pre_q <= 1'b0;
        end else if (wr_widen) begin
            if (lim_sel_q == tblo_pkg::LIM_GAIN) begin
                widen_gain_q <= w_data_q[0];
            end else if (lim_sel_q == tblo_pkg::LIM_PRELINES) begin
                widen_pre_q <= w_data_q[0];
            end
        end
    end

    // Dropping the widen flag returns the settings to reset values
    always_ff @(posedge clk_sys) begin
        if (rst || (wr_widen && lim_sel_q == tblo_pkg::LIM_GAIN && !w_data_q[0])) begin
            gain_all_q <= tblo_pkg::RST_SET;
            gain_tap_q <= '0;
        end else if (wr_gain) begin
            if (gain_sel_q == tblo_pkg::SEL_ALL) begin
                gain_all_q <= gain_res[SW-1:0];
            end else if (sel_tap_gain) begin
                gain_tap_q[gain_idx] <= gain_res[SW-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || (wr_widen && lim_sel_q == tblo_pkg::LIM_PRELINES && !w_data_q[0])) begin
            pre_q <= tblo_pkg::RST_PRELINES;
        end else if (wr_pre) begin
            pre_q <= pre_res[SW-1:0];
        end
    end

    // ----------------------------------------
    // AXI read channel
    // ----------------------------------------
    always_comb begin
        rd_d = 32'h0000_0000;
        case (s_axi_araddr)
            tblo_pkg::OFS_CTRL: rd_d = {30'h0, depth12_q, four_q};
            tblo_pkg::OFS_OFF_SEL: rd_d = {29'h0, off_sel_q};
            tblo_pkg::OFS_OFF_VAL: begin
                if (off_sel_q == tblo_pkg::SEL_ALL) begin
                    rd_d = 32'(off_all_q);
                end else if (sel_tap_off) begin
                    rd_d = 32'(off_tap_q[off_idx]);
                end
            end
            tblo_pkg::OFS_GAIN_SEL: rd_d = {29'h0, gain_sel_q};
            tblo_pkg::OFS_GAIN_VAL: begin
                if (gain_sel_q == tblo_pkg::SEL_ALL) begin
                    rd_d = 32'(gain_all_q);
                end else if (sel_tap_gain) begin
                    rd_d = 32'(gain_tap_q[gain_idx]);
                end
            end
            tblo_pkg::OFS_LIM_SEL: rd_d = {30'h0, lim_sel_q};
            tblo_pkg::OFS_WIDEN: begin
                rd_d[0] = (lim_sel_q == tblo_pkg::LIM_GAIN) ? widen_gain_q
                    : (lim_sel_q == tblo_pkg::LIM_PRELINES) && widen_pre_q;
            end
            tblo_pkg::OFS_PRELINES: rd_d = 32'(pre_q);
            tblo_pkg::OFS_STATUS: begin
                for (int i = 0; i < 4; i++) begin
                    rd_d[i] = four_q && ({1'b0, off_all_q} + {1'b0, off_tap_q[i]}
                        > tblo_pkg::OFF_SUM_MAX);
                end
            end
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tblo_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !ar_hs && (!s_axi_rvalid || s_axi_rready);
            if (ar_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= (s_axi_araddr > tblo_pkg::OFS_STATUS
                    || s_axi_araddr[1:0] != 2'b00) ? tblo_pkg::RESP_SLVERR
                    : tblo_pkg::RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Pixel offset path
    // ----------------------------------------
    logic [10:0] eff_off;
    logic [12:0] pix_sum;
    always_comb begin
        eff_off = {1'b0, off_all_q} + (four_q ? {1'b0, off_tap_q[pix_in.tap]} : 11'h0);
        if (depth12_q) begin
            pix_sum = {1'b0, pix_in.data} + 13'(eff_off >> tblo_pkg::SHIFT_12BIT);
            if (pix_sum > tblo_pkg::SAT_12BIT) begin
                pix_sum = tblo_pkg::SAT_12BIT;
            end
        end else begin
            pix_sum = {5'h00, pix_in.data[11:4]} + 13'(eff_off >> tblo_pkg::SHIFT_8BIT);
            if (pix_sum > tblo_pkg::SAT_8BIT) begin
                pix_sum = tblo_pkg::SAT_8BIT;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pix_out <= '0;
        end else begin
            pix_out.valid <= pix_in.valid;
            pix_out.tap <= pix_in.tap;
            pix_out.data <= pix_sum[11:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_out <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cfg_out.gain_eff[i] <= gain_all_q + (four_q ? gain_tap_q[i] : '0);
            end
            cfg_out.prelines <= pre_q;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_pix12_q0;
        pix_in.valid && four_q && depth12_q && pix_in.tap == 2'h0 && pix_in.data == 12'h000;
    endsequence

    a_quad_map_tl: assert property (s_pix12_q0 |=>
        pix_out.data == 12'((11'($past(off_all_q)) + 11'($past(off_tap_q[0]))) >> 2))
        else $error("top-left quadrant offset wrong");
    a_off_scale_8: assert property (pix_in.valid && !depth12_q && !four_q
        && pix_in.data == 12'h000 |=> pix_out.data == 12'($past(off_all_q) >> 6))
        else $error("8-bit offset scaling wrong");
    a_sat_8bit: assert property (pix_in.valid && !depth12_q ##1 1'b1
        |-> pix_out.data <= 12'h0ff && pix_out.valid)
        else $error("8-bit pixel above 255");
    a_sel_global_only: assert property (wr_off && off_sel_q == tblo_pkg::SEL_ALL
        |=> $stable(off_tap_q) && off_all_q == 10'($past(off_res)))
        else $error("global offset write disturbed taps");
    a_onetap_no_tap: assert property (wr_off && !four_q && off_sel_q != tblo_pkg::SEL_ALL
        |=> $stable(off_tap_q) && $stable(off_all_q))
        else $error("tap offset written in one-tap mode");
    a_gain_sum_lim: assert property (!widen_gain_q |->
        32'(gain_all_q) + 32'(gain_tmax) <= tblo_pkg::GAIN_MAX)
        else $error("gain sum above limit");
    a_widen_gain_set: assert property (wr_widen && lim_sel_q == tblo_pkg::LIM_GAIN
        |=> widen_gain_q == $past(w_data_q[0]))
        else $error("widen flag not taken");
    a_widen_others: assert property (wr_widen && lim_sel_q > tblo_pkg::LIM_PRELINES
        |=> $stable({widen_gain_q, widen_pre_q}))
        else $error("widen flag set for fixed parameter");
    a_pre_clamp: assert property (wr_pre && !widen_pre_q && w_data_q > tblo_pkg::PRE_MAX
        |=> 32'(pre_q) == tblo_pkg::PRE_MAX)
        else $error("prelines not clamped to maximum");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule

/* test/tblo_tap_src.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Readout tap model
// ----------------------------------------
module tblo_tap_src (
    // Clock
    input wire logic clk_sys,
    // Command from bench
    input wire logic go,
    input wire logic [1:0] tap,
    input wire logic [11:0] data,
    // Pixel to block
    output tblo_pkg::tblo_pix_s pix
);
    initial pix = '0;
    // Idle data toggles so stale values never look valid
    always @(posedge clk_sys) begin
        if (go) begin
            pix <= {1'b1, tap, data};
        end else begin
            pix.valid <= 1'b0;
            pix.data <= ~pix.data;
        end
    end
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 0;
    logic rst = 1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic go = 0;
    logic [1:0] tap = '0;
    logic [11:0] data = '0;
    tblo_pkg::tblo_pix_s pix_in, pix_out;
    tblo_pkg::tblo_cfg_s cfg_out;
    int failures = 0, compares = 0;
    int ov[5] = '{100, 4, 8, 12, 400};

    tblo_offset_top tblo_offset_top_i (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pix_in, .pix_out, .cfg_out);
    tblo_tap_src tblo_tap_src_i (.clk_sys, .go, .tap, .data, .pix(pix_in));

    initial forever #2 clk_sys = ~clk_sys;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 0;
                return;
            end
        end
        failures++;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 0;
                chk(nm, rd, exp);
                return;
            end
        end
        failures++;
    endtask
    function automatic logic [11:0] ex(input logic [11:0] d, input int eff, input bit d12);
        int s;
        int m;
        s = d12 ? d + eff / 4 : d[11:4] + eff / 64;
        m = d12 ? 4095 : 255;
        return (s > m) ? m[11:0] : s[11:0];
    endfunction
    task automatic px(input logic [1:0] t, input logic [11:0] d, input logic [11:0] e);
        @(posedge clk_sys);
        go <= 1;
        tap <= t;
        data <= d;
        @(posedge clk_sys);
        go <= 0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("pix_out", pix_out, {1'b1, t, e});
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        rc("ctrl", tblo_pkg::OFS_CTRL, 32'h1);
        rc("prelines", tblo_pkg::OFS_PRELINES, 32'h1);
        $display("test reset done");
        wr(tblo_pkg::OFS_CTRL, 32'h3);
        for (int i = 0; i < 5; i++) begin
            wr(tblo_pkg::OFS_OFF_SEL, i);
            wr(tblo_pkg::OFS_OFF_VAL, ov[i]);
        end
        for (int i = 0; i < 5; i++) begin
            wr(tblo_pkg::OFS_OFF_SEL, i);
            rc("off_val", tblo_pkg::OFS_OFF_VAL, ov[i]);
        end
        for (int i = 0; i < 4; i++) px(2'(i), 12'h100, ex(12'h100, ov[0] + ov[i+1], 1));
        px(3, 12'hff0, 12'hfff);
        wr(tblo_pkg::OFS_CTRL, 32'h1);
        px(0, 12'h800, ex(12'h800, 104, 0));
        wr(tblo_pkg::OFS_OFF_SEL, 0);
        wr(tblo_pkg::OFS_OFF_VAL, 164);
        px(0, 12'h800, ex(12'h800, 168, 0));
        px(3, 12'hff0, 12'h0ff);
        $display("test offsets done");
        wr(tblo_pkg::OFS_CTRL, 32'h3);
        wr(tblo_pkg::OFS_OFF_VAL, 0);
        wr(tblo_pkg::OFS_OFF_SEL, 4);
        wr(tblo_pkg::OFS_OFF_VAL, 1000);
        rc("off_clamp", tblo_pkg::OFS_OFF_VAL, 32'h3b6);
        px(3, 12'h000, ex(12'h000, 950, 1));
        px(0, 12'h000, ex(12'h000, 4, 1));
        wr(tblo_pkg::OFS_GAIN_VAL, 700);
        rc("gain_clamp", tblo_pkg::OFS_GAIN_VAL, 32'h258);
        wr(tblo_pkg::OFS_GAIN_VAL, 500);
        wr(tblo_pkg::OFS_GAIN_SEL, 1);
        wr(tblo_pkg::OFS_GAIN_VAL, 200);
        rc("gain_tap", tblo_pkg::OFS_GAIN_VAL, 32'd100);
        chk("gain_eff", cfg_out.gain_eff[0], 32'd600);
        wr(tblo_pkg::OFS_LIM_SEL, tblo_pkg::LIM_GAIN);
        wr(tblo_pkg::OFS_WIDEN, 1);
        wr(tblo_pkg::OFS_GAIN_SEL, 0);
        wr(tblo_pkg::OFS_GAIN_VAL, 900);
        rc("gain_wide", tblo_pkg::OFS_GAIN_VAL, 32'd900);
        wr(tblo_pkg::OFS_PRELINES, 0);
        rc("pre_lo", tblo_pkg::OFS_PRELINES, 32'd1);
        wr(tblo_pkg::OFS_PRELINES, 20);
        rc("pre_hi", tblo_pkg::OFS_PRELINES, 32'd15);
        wr(tblo_pkg::OFS_LIM_SEL, tblo_pkg::LIM_PRELINES);
        wr(tblo_pkg::OFS_WIDEN, 1);
        wr(tblo_pkg::OFS_PRELINES, 100);
        rc("pre_wide", tblo_pkg::OFS_PRELINES, 32'd63);
        chk("cfg_pre", cfg_out.prelines, 32'd63);
        wr(tblo_pkg::OFS_LIM_SEL, 2);
        wr(tblo_pkg::OFS_WIDEN, 1);
        rc("widen_other", tblo_pkg::OFS_WIDEN, 32'h0);
        $display("test limits done");
        wr(tblo_pkg::OFS_CTRL, 32'h2);
        wr(tblo_pkg::OFS_OFF_SEL, 0);
        wr(tblo_pkg::OFS_OFF_VAL, 40);
        px(3, 12'h100, ex(12'h100, 40, 1));
        wr(tblo_pkg::OFS_OFF_SEL, 4);
        wr(tblo_pkg::OFS_OFF_VAL, 500);
        rc("one_tap_off", tblo_pkg::OFS_OFF_VAL, 32'h0);
        wr(tblo_pkg::OFS_GAIN_SEL, 1);
        rc("one_tap_gain", tblo_pkg::OFS_GAIN_VAL, 32'h0);
        chk("gain_eff_1tap", cfg_out.gain_eff[0], 32'd900);
        rc("unmapped_rd", 8'h24, 32'h0);
        chk("rresp", resp, tblo_pkg::RESP_SLVERR);
        wr(8'h28, 32'h1);
        chk("bresp", resp, tblo_pkg::RESP_SLVERR);
        $display("test one tap done");
        wr(tblo_pkg::OFS_OFF_SEL, 0);
        wr(tblo_pkg::OFS_OFF_VAL, 0);
        wr(tblo_pkg::OFS_CTRL, 32'h3);
        for (int i = 1; i < 5; i++) begin
            wr(tblo_pkg::OFS_OFF_SEL, i);
            wr(tblo_pkg::OFS_OFF_VAL, 0);
        end
        wr(tblo_pkg::OFS_OFF_SEL, 0);
        wr(tblo_pkg::OFS_OFF_VAL, 200);
        for (int i = 0; i < 4; i++) px(2'(i), 12'h100, ex(12'h100, 200, 1));
        rc("status", tblo_pkg::OFS_STATUS, 32'h0);
        wr(tblo_pkg::OFS_CTRL, 32'h0);
        px(2, 12'h000, ex(12'h000, 200, 0));
        $display("test balance done");
        @(posedge clk_sys);
        rst <= 1;
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        rc("ctrl_again", tblo_pkg::OFS_CTRL, 32'h1);
        rc("gain_again", tblo_pkg::OFS_GAIN_VAL, 32'h0);
        rc("pre_again", tblo_pkg::OFS_PRELINES, 32'h1);
        $display("test mid reset done");
        print_verdict();
    end

    initial begin
        #40000;
        failures++;
        print_verdict();
    end
endmodule
